// >>> slps_host_model.sv
// Purpose: Host side model issuing configuration reads to the status block
// Assumes: Read strobe lasts one cycle, data is valid the cycle after it
// Notes: Index is scrambled once the strobe is dropped
`timescale 1ns/1ps
module slps_host_model (
    input wire logic i_core_clk,
    input wire logic [7:0] i_cfg_rdata,
    output logic o_cfg_rd,
    output logic [7:0] o_cfg_index
);
    ////////////////////////////////////////////////////////////////////////////
    // Idle bus at time zero
    initial
    begin
        o_cfg_rd = 1'b0;
        o_cfg_index = 8'h5a;
    end

    // One read: strobe from a falling edge, data taken one cycle later
    task automatic rd(input logic [7:0] idx, output logic [7:0] data);
        @(negedge i_core_clk);
        o_cfg_rd = 1'b1;
        o_cfg_index = idx;
        @(negedge i_core_clk);
        o_cfg_rd = 1'b0;
        o_cfg_index = ~idx; // No stale index once released
        data = i_cfg_rdata;
    endtask : rd
endmodule : slps_host_model

// >>> slps_idle_timer.sv
// Purpose: Secondary hard disk idle timer
// Assumes: Activity pulse and tick enable on the core clock
// Notes: Reloads on activity, one expiry pulse per idle period
`timescale 1ns/1ps
`include "slps_regs.svh"
module slps_idle_timer #(
    parameter int WIDTH = `SLPS_IDLE_WIDTH
) (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_enable,
    input wire logic i_tick,
    input wire logic i_activity,
    input wire logic [WIDTH-1:0] i_load,
    output logic o_expire
);

    logic [WIDTH-1:0] count;
    logic armed;
    logic next_expire;

    // Expiry when the last tick of an armed count lands
    assign next_expire = i_enable && armed && !i_activity && i_tick &&
                         (count == {{(WIDTH-1){1'b0}}, 1'b1});

    // Countdown reloaded by activity or disable
    always_ff @(posedge i_core_clk)
    begin
        if (!i_reset_n)
        begin
            count <= '0;
            armed <= 1'b0;
            o_expire <= 1'b0;
        end
        else
        begin
            o_expire <= next_expire;
            if (!i_enable || i_activity)
            begin
                count <= i_load;
                armed <= (i_load != '0);
            end
            else if (armed && i_tick)
            begin
                count <= count - 1'b1;
                armed <= (count != {{(WIDTH-1){1'b0}}, 1'b1});
            end
        end
    end

endmodule : slps_idle_timer

// >>> slps_pkg.sv
// Purpose: Types for the PM SMI status block
// Assumes: Used with slps_regs.svh
// Notes: Read-access classes of the configuration decode
package slps_pkg;

    // Decode result of a configuration read
    typedef enum logic [4:0] {
        SLPS_RD_NONE = 5'b00001,
        SLPS_RD_TRAP = 5'b00010,
        SLPS_RD_MISC = 5'b00100,
        SLPS_RD_TMIR = 5'b01000,
        SLPS_RD_MMIR = 5'b10000
    } slps_rd_t;

endpackage : slps_pkg

// >>> slps_regs.svh
// Purpose: Offsets, field positions, reset values for the PM SMI status block
// Assumes: 8-bit configuration space, byte index addressing
// Notes: Included by the idle timer, the status block and the testbench
`ifndef SLPS_REGS_SVH
`define SLPS_REGS_SVH

// Register indices
`define SLPS_IDX_TRAP_MIRROR 8'h86
`define SLPS_IDX_MISC_MIRROR 8'h87
`define SLPS_IDX_TRAP_STATUS 8'hf6
`define SLPS_IDX_MISC_STATUS 8'hf7
`define SLPS_IDX_RSVD_LO 8'hf8
`define SLPS_IDX_RSVD_HI 8'hff

// Reset values
`define SLPS_TRAP_RESET 8'h00
`define SLPS_MISC_RESET 8'h00

// Trap register bit positions
`define SLPS_TRAP_PRI_HD 0
`define SLPS_TRAP_FLOPPY 1
`define SLPS_TRAP_SER_PAR 2
`define SLPS_TRAP_KBD_MS 3
`define SLPS_TRAP_SEC_IDLE 4
`define SLPS_TRAP_SEC_HD 5
`define SLPS_TRAP_RSVD 6

// Miscellaneous register bit positions
`define SLPS_MISC_ACPI 0
`define SLPS_MISC_RTC 1
`define SLPS_MISC_CODEC 2
`define SLPS_MISC_LID_EVT 3
`define SLPS_MISC_LID_POS 4
`define SLPS_MISC_PIN0 5

// Idle timer count width
`define SLPS_IDLE_WIDTH 16

`endif

// >>> slps_status.sv
// Purpose: Second-level PM SMI status for device traps and misc events
// Assumes: Config reads are one-cycle strobes with an 8-bit index
// Notes: Read data is registered one cycle after the strobe
//
// What this block does
// RQ1: Secondary disk trap sets bit five
// RQ2: Secondary disk idle expiry sets bit four
// RQ3: Keyboard/mouse trap sets bit three
// RQ4: Serial/parallel trap sets bit two
// RQ5: Floppy trap sets bit one
// RQ6: Primary disk trap sets bit zero
// RQ7: Trap bits set only when enabled, raising SMI
// RQ8: Trap read clears; mirror reads without clearing
// RQ9: General pin transitions set bits seven to five
// RQ10: Pin counts only if GPIO, input, enabled
// RQ11: Lid position bit follows lid pin level while lid select is set, reads zero otherwise
// RQ12: Lid transition sets bit three when configured
// RQ13: Codec data-in rising edge sets bit two
// RQ14: RTC alarm sets bit one in suspend
// RQ15: ACPI timer MSB toggle sets bit zero
// RQ16: Any status except lid position drives top PM SMI bit
// RQ17: Misc read clears; mirror copy at 87h
// RQ18: Reserved bit six and F8h-FFh read zero
// RQ19: Set wins over clearing read
`timescale 1ns/1ps
`include "slps_regs.svh"
module slps_status
    import slps_pkg::*;
#(
    parameter int IDLE_WIDTH = `SLPS_IDLE_WIDTH
) (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_cfg_rd,
    input wire logic [7:0] i_cfg_index,
    input wire logic i_trap_pri_hd,
    input wire logic i_trap_floppy,
    input wire logic i_trap_ser_par,
    input wire logic i_trap_kbd_ms,
    input wire logic i_trap_sec_hd,
    input wire logic i_trap_en_pri_hd,
    input wire logic i_trap_en_floppy,
    input wire logic i_trap_en_ser_par,
    input wire logic i_trap_en_kbd_ms,
    input wire logic i_trap_en_sec_hd,
    input wire logic i_sec_idle_en,
    input wire logic i_idle_tick,
    input wire logic [IDLE_WIDTH-1:0] i_sec_idle_count,
    input wire logic i_general_pin_zero,
    input wire logic i_general_pin_one,
    input wire logic i_general_pin_two,
    input wire logic i_lid_switch_pin,
    input wire logic [2:0] i_pin_gpio_en,
    input wire logic [2:0] i_pin_is_output,
    input wire logic [2:0] i_pin_smi_en,
    input wire logic i_lid_is_output,
    input wire logic i_lid_select,
    input wire logic i_codec_sdata_in,
    input wire logic i_codec_smi_en,
    input wire logic i_rtc_alarm,
    input wire logic i_suspend_3v,
    input wire logic i_acpi_msb,
    input wire logic i_acpi_smi_en,
    output logic [7:0] o_cfg_rdata,
    output logic o_pm_smi,
    output logic o_smi_req
);

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [5:0] pin_level;
    logic [5:0] pin_rise;
    logic [5:0] pin_fall;

    // Bits: 0-2 general pins, 3 lid, 4 codec, 5 rtc
    slps_sync_edge #(
        .WIDTH(6)
    ) i_slps_sync_edge (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_async({i_rtc_alarm, i_codec_sdata_in, i_lid_switch_pin,
                  i_general_pin_two, i_general_pin_one, i_general_pin_zero}),
        .o_level(pin_level),
        .o_rise(pin_rise),
        .o_fall(pin_fall)
    );

    ////////////////////////////////////////////////////////////////////
    // Secondary disk idle timer

    logic sec_idle_expire;

    slps_idle_timer #(
        .WIDTH(IDLE_WIDTH)
    ) i_slps_idle_timer (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_enable(i_sec_idle_en),
        .i_tick(i_idle_tick),
        .i_activity(i_trap_sec_hd),
        .i_load(i_sec_idle_count),
        .o_expire(sec_idle_expire)
    );

    ////////////////////////////////////////////////////////////////////
    // Read decode

    slps_rd_t rd_kind;
    wire hit_trap = i_cfg_index == `SLPS_IDX_TRAP_STATUS;
    wire hit_misc = i_cfg_index == `SLPS_IDX_MISC_STATUS;
    wire hit_tmir = i_cfg_index == `SLPS_IDX_TRAP_MIRROR;
    wire hit_mmir = i_cfg_index == `SLPS_IDX_MISC_MIRROR;

    // Reserved indices fall through to none
    assign rd_kind = !i_cfg_rd ? SLPS_RD_NONE :
                     hit_trap ? SLPS_RD_TRAP :
                     hit_misc ? SLPS_RD_MISC :
                     hit_tmir ? SLPS_RD_TMIR :
                     hit_mmir ? SLPS_RD_MMIR : SLPS_RD_NONE; // [RQ18]

    wire clr_trap = rd_kind == SLPS_RD_TRAP; // [RQ8]
    wire clr_misc = rd_kind == SLPS_RD_MISC; // [RQ17]

    ////////////////////////////////////////////////////////////////////
    // Event sources

    logic [7:0] trap_set;
    logic [7:0] misc_set;
    logic [2:0] pin_evt;
    logic acpi_prev;

    // Trap events gated by their enables
    assign trap_set[`SLPS_TRAP_PRI_HD] = i_trap_pri_hd & i_trap_en_pri_hd; // [RQ6] [RQ7]
    assign trap_set[`SLPS_TRAP_FLOPPY] = i_trap_floppy & i_trap_en_floppy; // [RQ5] [RQ7]
    assign trap_set[`SLPS_TRAP_SER_PAR] = i_trap_ser_par & i_trap_en_ser_par; // [RQ4] [RQ7]
    assign trap_set[`SLPS_TRAP_KBD_MS] = i_trap_kbd_ms & i_trap_en_kbd_ms; // [RQ3] [RQ7]
    assign trap_set[`SLPS_TRAP_SEC_IDLE] = sec_idle_expire & i_sec_idle_en; // [RQ2]
    assign trap_set[`SLPS_TRAP_SEC_HD] = i_trap_sec_hd & i_trap_en_sec_hd; // [RQ1] [RQ7]
    assign trap_set[7:6] = 2'b00; // [RQ18]

    // Properly configured general pin transitions
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_pin
            assign pin_evt[g] = (pin_rise[g] | pin_fall[g]) & i_pin_gpio_en[g] &
                                ~i_pin_is_output[g] & i_pin_smi_en[g]; // [RQ10]
        end
    endgenerate

    // Miscellaneous events
    wire lid_cfg = ~i_lid_is_output & i_lid_select;
    wire acpi_toggle = (i_acpi_msb != acpi_prev) & i_acpi_smi_en;
    assign misc_set[7:5] = pin_evt; // [RQ9]
    assign misc_set[`SLPS_MISC_LID_POS] = 1'b0;
    assign misc_set[`SLPS_MISC_LID_EVT] = (pin_rise[3] | pin_fall[3]) & lid_cfg; // [RQ12]
    assign misc_set[`SLPS_MISC_CODEC] = pin_rise[4] & i_codec_smi_en; // [RQ13]
    assign misc_set[`SLPS_MISC_RTC] = pin_rise[5] & i_suspend_3v; // [RQ14]
    assign misc_set[`SLPS_MISC_ACPI] = acpi_toggle; // [RQ15]

    ////////////////////////////////////////////////////////////////////
    // Status registers

    logic [7:0] trap_status;
    logic [7:0] misc_sticky;
    logic lid_pos;
    logic [7:0] next_trap;
    logic [7:0] next_misc;
    logic [7:0] misc_view;

    // Set wins over a clearing read
    assign next_trap = (clr_trap ? 8'h00 : trap_status) | trap_set; // [RQ19]
    assign next_misc = (clr_misc ? 8'h00 : misc_sticky) | misc_set; // [RQ19]
    assign misc_view = {misc_sticky[7:5], lid_pos, misc_sticky[3:0]};

    // Sticky status and lid level
    always_ff @(posedge i_core_clk)
    begin
        if (!i_reset_n)
        begin
            trap_status <= `SLPS_TRAP_RESET;
            misc_sticky <= `SLPS_MISC_RESET;
            lid_pos <= 1'b0;
            acpi_prev <= 1'b0;
        end
        else
        begin
            trap_status <= next_trap; // [RQ8]
            misc_sticky <= next_misc; // [RQ17]
            lid_pos <= i_lid_select ? pin_level[3] : 1'b0; // [RQ11]
            acpi_prev <= i_acpi_msb;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data and SMI outputs

    logic [7:0] next_rdata;

    // Clearing and mirror reads return the same value
    always_comb
    begin
        next_rdata = 8'h00;
        case (rd_kind)
            SLPS_RD_TRAP: next_rdata = trap_status;
            SLPS_RD_TMIR: next_rdata = trap_status; // [RQ8]
            SLPS_RD_MISC: next_rdata = misc_view;
            SLPS_RD_MMIR: next_rdata = misc_view; // [RQ17]
            SLPS_RD_NONE: next_rdata = 8'h00; // [RQ18]
            default: next_rdata = 8'h00;
        endcase
    end

    wire any_pending = (next_trap != 8'h00) || (next_misc != 8'h00);

    // Registered outputs
    always_ff @(posedge i_core_clk)
    begin
        if (!i_reset_n)
        begin
            o_cfg_rdata <= 8'h00;
            o_pm_smi <= 1'b0;
            o_smi_req <= 1'b0;
        end
        else
        begin
            o_cfg_rdata <= next_rdata;
            o_pm_smi <= any_pending; // [RQ16]
            o_smi_req <= any_pending; // [RQ7]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions

    a_trap_sets: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [RQ7]
        trap_set[`SLPS_TRAP_SEC_HD] |=> trap_status[`SLPS_TRAP_SEC_HD])
        else $error("trap bit five not set");

    a_trap_gate: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [RQ6]
        (!trap_status[0] && !i_trap_en_pri_hd && !clr_trap) |=> !trap_status[0])
        else $error("trap bit zero set while disabled");

    a_trap_clear: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [RQ8]
        (clr_trap && trap_set == 8'h00) |=> trap_status == 8'h00)
        else $error("trap read did not clear");

    a_mirror_keep: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [RQ8]
        (rd_kind == SLPS_RD_TMIR) |=> (trap_status == $past(trap_status)) ||
        ($past(trap_set) != 8'h00))
        else $error("trap mirror read changed status");

    a_set_wins: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [RQ19]
        (clr_misc && misc_set[0]) |=> misc_sticky[0])
        else $error("event lost on clearing read");

    a_rsvd_zero: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [RQ18]
        (i_cfg_rd && i_cfg_index >= `SLPS_IDX_RSVD_LO) |=> o_cfg_rdata == 8'h00)
        else $error("reserved index read nonzero");

    a_pm_smi_roll: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [RQ16]
        (trap_status != 8'h00 || misc_sticky != 8'h00) |-> o_pm_smi)
        else $error("top PM bit missing");

    a_rtc_suspend: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [RQ14]
        (!misc_sticky[1] && !i_suspend_3v) |=> !misc_sticky[1])
        else $error("rtc bit set outside suspend");

    a_misc_clear: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [RQ17]
        (clr_misc && misc_set == 8'h00) ##1 (misc_set == 8'h00) |=> misc_sticky == 8'h00)
        else $error("misc read did not clear");

    a_trap_raise_smi: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [RQ7]
        (trap_set != 8'h00) |=> o_smi_req)
        else $error("trap event raised no SMI request");

    a_idle_gate: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [RQ2]
        (!trap_status[`SLPS_TRAP_SEC_IDLE] && !i_sec_idle_en) |=> !trap_status[`SLPS_TRAP_SEC_IDLE])
        else $error("idle bit set while timer disabled");

    a_pin_gate: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [RQ10]
        (!misc_sticky[5] && !(i_pin_gpio_en[0] && !i_pin_is_output[0] && i_pin_smi_en[0]))
        |=> !misc_sticky[5])
        else $error("pin zero event counted while not configured");

    a_lid_follow: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [RQ11]
        (i_lid_select && pin_level[3]) |=> lid_pos)
        else $error("lid position does not follow pin");

    a_lid_hidden: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [RQ11]
        !i_lid_select |=> !lid_pos)
        else $error("lid position shown while not selected");

    a_lid_gate: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [RQ12]
        (!misc_sticky[`SLPS_MISC_LID_EVT] && !lid_cfg) |=> !misc_sticky[`SLPS_MISC_LID_EVT])
        else $error("lid event set while not configured");

    a_codec_edge: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [RQ13]
        (pin_rise[4] && i_codec_smi_en) |=> misc_sticky[`SLPS_MISC_CODEC])
        else $error("codec rising edge not recorded");

    a_acpi_gate: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [RQ15]
        (!misc_sticky[`SLPS_MISC_ACPI] && !i_acpi_smi_en) |=> !misc_sticky[`SLPS_MISC_ACPI])
        else $error("timer toggle set while disabled");

    a_rdata_idle: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [RQ18]
        !i_cfg_rd |=> o_cfg_rdata == 8'h00)
        else $error("read data nonzero without a read");

    a_mirror_data: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [RQ8]
        (rd_kind == SLPS_RD_TMIR) |=> o_cfg_rdata == $past(trap_status))
        else $error("trap mirror returned wrong value");

endmodule : slps_status

// >>> slps_sync_edge.sv
// Purpose: Two-flop synchroniser with edge detection per bit
// Assumes: Inputs asynchronous to i_core_clk
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module slps_sync_edge #(
    parameter int WIDTH = 6
) (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_level,
    output logic [WIDTH-1:0] o_rise,
    output logic [WIDTH-1:0] o_fall
);

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0] prev;

    // Per-bit synchroniser and history
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_bit
            always_ff @(posedge i_core_clk)
            begin
                if (!i_reset_n)
                begin
                    meta[g] <= 1'b0;
                    stable[g] <= 1'b0;
                    prev[g] <= 1'b0;
                end
                else
                begin
                    meta[g] <= i_async[g];
                    stable[g] <= meta[g];
                    prev[g] <= stable[g];
                end
            end
        end
    endgenerate

    // Edges from the synchronised level
    assign o_level = stable;
    assign o_rise = stable & ~prev;
    assign o_fall = ~stable & prev;

endmodule : slps_sync_edge

// >>> tb_second_level_pm_smi_status.sv
// Purpose: Self-checking bench for the second-level PM SMI status block
// Assumes: Inputs change on falling edges, reads through the host model
// Notes: Idle count shortened to 3 ticks, tick held high
`timescale 1ns/1ps
`include "slps_regs.svh"
module tb_second_level_pm_smi_status;
    logic clk, rst_n, idle_en, lid, lid_sel, lid_out, codec, codec_en, rtc, susp, acpi, acpi_en;
    logic pm_smi, smi_req, cfg_rd;
    logic [4:0] trap, trap_en;
    logic [2:0] gp, gp_en, gp_out, gp_smi;
    logic [7:0] idx, rdata;
    int err_total, check_count;
    int tbit [5] = '{0, 1, 2, 3, 5};

    ////////////////////////////////////////////////////////////////////////////
    // Device under test and host model
    slps_status i_slps_status (.i_core_clk(clk), .i_reset_n(rst_n), .i_cfg_rd(cfg_rd),
        .i_cfg_index(idx), .i_trap_pri_hd(trap[0]), .i_trap_floppy(trap[1]),
        .i_trap_ser_par(trap[2]), .i_trap_kbd_ms(trap[3]), .i_trap_sec_hd(trap[4]),
        .i_trap_en_pri_hd(trap_en[0]), .i_trap_en_floppy(trap_en[1]),
        .i_trap_en_ser_par(trap_en[2]), .i_trap_en_kbd_ms(trap_en[3]),
        .i_trap_en_sec_hd(trap_en[4]), .i_sec_idle_en(idle_en), .i_idle_tick(1'b1),
        .i_sec_idle_count(16'h0003), .i_general_pin_zero(gp[0]), .i_general_pin_one(gp[1]),
        .i_general_pin_two(gp[2]), .i_lid_switch_pin(lid), .i_pin_gpio_en(gp_en),
        .i_pin_is_output(gp_out), .i_pin_smi_en(gp_smi), .i_lid_is_output(lid_out),
        .i_lid_select(lid_sel), .i_codec_sdata_in(codec), .i_codec_smi_en(codec_en),
        .i_rtc_alarm(rtc), .i_suspend_3v(susp), .i_acpi_msb(acpi), .i_acpi_smi_en(acpi_en),
        .o_cfg_rdata(rdata), .o_pm_smi(pm_smi), .o_smi_req(smi_req));
    slps_host_model i_host (.i_core_clk(clk), .i_cfg_rdata(rdata), .o_cfg_rd(cfg_rd),
        .o_cfg_index(idx));

    ////////////////////////////////////////////////////////////////////////////
    // Clock at 200 MHz
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Compare one byte
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Read one index and compare
    task automatic rd_chk(input logic [7:0] ix, input logic [7:0] exp);
        logic [7:0] v;
        i_host.rd(ix, v);
        chk(v, exp);
    endtask : rd_chk

    // One-cycle trap pulse
    task automatic pulse(input int i);
        @(negedge clk);
        trap[i] = 1'b1;
        @(negedge clk);
        trap[i] = 1'b0;
    endtask : pulse

    // Mirror twice, SMI level, clearing read, mirror and SMI after it
    task automatic ev_chk(input logic [7:0] mir, input logic [7:0] exp);
        logic [7:0] keep;
        logic s;
        keep = (mir == `SLPS_IDX_MISC_MIRROR) ? (exp & 8'h10) : 8'h00;
        s = |(exp & ~keep);
        repeat (5) @(negedge clk);
        rd_chk(mir, exp);
        rd_chk(mir, exp);
        chk({6'h00, pm_smi, smi_req}, {6'h00, s, s});
        rd_chk(mir + 8'h70, exp);
        rd_chk(mir, keep);
        chk({6'h00, pm_smi, smi_req}, 8'h00);
    endtask : ev_chk

    // Counts and verdict
    task automatic stop_test;
        $display("Checks %0d, errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog against a hang
    initial
    begin
        #20000;
        err_total++;
        stop_test();
    end

    // Main sequence
    initial
    begin
        {rst_n, idle_en, lid, lid_sel, codec, codec_en, rtc, susp, acpi, acpi_en} = '0;
        {lid_out, trap, trap_en, gp, gp_en, gp_out, gp_smi} = '0;
        err_total = 0;
        check_count = 0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        rd_chk(`SLPS_IDX_TRAP_STATUS, `SLPS_TRAP_RESET);
        rd_chk(`SLPS_IDX_MISC_STATUS, `SLPS_MISC_RESET);
        rd_chk(`SLPS_IDX_RSVD_LO, 8'h00);
        rd_chk(`SLPS_IDX_RSVD_HI, 8'h00);
        // Each trap source refused while disabled, then set
        for (int i = 0; i < 5; i++)
        begin
            pulse(i);
            ev_chk(`SLPS_IDX_TRAP_MIRROR, 8'h00);
            trap_en[i] = 1'b1;
            pulse(i);
            ev_chk(`SLPS_IDX_TRAP_MIRROR, 8'h01 << tbit[i]);
            trap_en[i] = 1'b0;
        end
        // Event lands in the same cycle as the clearing read
        trap_en[0] = 1'b1;
        fork
            rd_chk(`SLPS_IDX_TRAP_STATUS, 8'h00);
            pulse(0);
        join
        ev_chk(`SLPS_IDX_TRAP_MIRROR, 8'h01);
        idle_en = 1'b1;
        ev_chk(`SLPS_IDX_TRAP_MIRROR, 8'h10);
        idle_en = 1'b0;
        // General pins: refused unless enabled, input and SMI-enabled
        gp_en = 3'h7;
        gp_smi = 3'h7;
        gp_out = 3'h7;
        for (int i = 0; i < 3; i++)
        begin
            gp[i] = ~gp[i];
            ev_chk(`SLPS_IDX_MISC_MIRROR, 8'h00);
            gp_out[i] = 1'b0;
            gp_en[i] = 1'b0;
            gp[i] = ~gp[i];
            ev_chk(`SLPS_IDX_MISC_MIRROR, 8'h00);
            gp_en[i] = 1'b1;
            gp_smi[i] = 1'b0;
            gp[i] = ~gp[i];
            ev_chk(`SLPS_IDX_MISC_MIRROR, 8'h00);
            gp_smi[i] = 1'b1;
            gp[i] = ~gp[i];
            ev_chk(`SLPS_IDX_MISC_MIRROR, 8'h20 << i);
        end
        // Lid pin: transition refused as output, set as input, level shown while selected; then codec, RTC and ACPI events
        lid_sel = 1'b1;
        lid_out = 1'b1;
        lid = 1'b1;
        ev_chk(`SLPS_IDX_MISC_MIRROR, 8'h10);
        lid_out = 1'b0;
        lid = 1'b0;
        ev_chk(`SLPS_IDX_MISC_MIRROR, 8'h08);
        lid = 1'b1;
        ev_chk(`SLPS_IDX_MISC_MIRROR, 8'h18);
        lid_sel = 1'b0;
        lid = 1'b0;
        ev_chk(`SLPS_IDX_MISC_MIRROR, 8'h00);
        codec_en = 1'b1;
        codec = 1'b1;
        ev_chk(`SLPS_IDX_MISC_MIRROR, 8'h04);
        codec = 1'b0;
        ev_chk(`SLPS_IDX_MISC_MIRROR, 8'h00);
        rtc = 1'b1;
        ev_chk(`SLPS_IDX_MISC_MIRROR, 8'h00);
        rtc = 1'b0;
        susp = 1'b1;
        ev_chk(`SLPS_IDX_MISC_MIRROR, 8'h00);
        rtc = 1'b1;
        ev_chk(`SLPS_IDX_MISC_MIRROR, 8'h02);
        acpi = 1'b1;
        ev_chk(`SLPS_IDX_MISC_MIRROR, 8'h00);
        acpi_en = 1'b1;
        acpi = 1'b0;
        ev_chk(`SLPS_IDX_MISC_MIRROR, 8'h01);
        stop_test();
    end
endmodule : tb_second_level_pm_smi_status
